// ===== core/dmaf_top.v
// Purpose: data memory address generation, indirect pointers and alu flag register
// Assumes: core strobes are one-cycle pulses synchronous to pclk; ram read data is valid in the ram_en cycle
// Notes: apb slave answers with zero wait states
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "dmaf_map.vh"

// Functional notes
// [RULE1] bank select low nibble forms address top
// [RULE2] bank select upper nibble reads zero
// [RULE3] unimplemented bank: read zero, write ignored; the code still reads and writes the registers held here
// [RULE4] sixteen banks of 256 bytes
// [RULE5] move file to file ignores bank
// [RULE6] access bit overrides bank select
// [RULE7] three 12-bit pointers as byte pairs
// [RULE8] indirect locations access pointed memory
// [RULE9] self-pointing indirect: read zero, write nop
// [RULE10] five access modes per pointer
// [RULE11] indexed adds signed working register
// [RULE12] pointer stepping leaves flags alone
// [RULE13] pointer steps carry across 12 bits
// [RULE14] write to pointer beats auto step
// [RULE15] computed flags beat data write
// [RULE16] flag bits 7 to 5 read zero
// [RULE17] negative copies result msb
// [RULE18] overflow on signed sign change
// [RULE19] zero set on zero result
// [RULE20] digit carry from bit 3 or rotate
// [RULE21] carry from result msb
// [RULE22] rotate loads carry from end bit
// [RULE23] subtract carries act as inverted borrow
// [RULE24] indexed sum wraps, offset sign-extended
module dmaf_top (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // core access request
  input wire core_req,
  input wire core_we,
  input wire [7:0] core_addr,
  input wire core_access,
  input wire core_mff,
  input wire [11:0] core_mff_addr,
  input wire [7:0] core_wdata,
  input wire [7:0] working_register,
  input wire core_bank_load,
  input wire [7:0] core_bank_lit,
  // alu flag update
  input wire [2:0] alu_op,
  input wire [7:0] alu_a,
  input wire [7:0] alu_b,
  input wire alu_cin,
  input wire [7:0] alu_result,
  // core answer
  output reg [7:0] core_rdata,
  output reg core_rvalid,
  output reg [7:0] alu_flags,
  output reg [7:0] bank_select_reg,
  // static ram port
  output reg ram_en,
  output reg ram_we,
  output reg [11:0] ram_addr,
  output reg [7:0] ram_wdata,
  input wire [7:0] ram_rdata
);

  reg [11:0] indirect_pointer [0:2];
  reg [15:0] bank_impl;
  reg [1:0] rd_state;
  reg rd_zero;
  reg [7:0] rd_local;
  reg rd_use_local;
  reg [7:0] next_flags;
  reg [11:0] eff_addr;
  reg is_ind;
  reg [1:0] ind_sel;
  reg [2:0] ind_mode;
  reg self_ptr;
  reg [5:0] self_dec;
  reg [3:0] sel_bank;
  reg [8:0] sum9;
  reg [4:0] sum5;
  reg [7:0] b_eff;
  reg [31:0] rd_mux;
  reg addr_ok;
  reg [7:0] loc_data;
  reg loc_hit;
  wire [11:0] full_addr;
  wire apb_wr;
  wire apb_rd;
  wire bank_ok;

  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;

  // a write lands in the access cycle, a read is captured at setup
  assign apb_wr = psel & penable & pwrite & pready;
  assign apb_rd = psel & ~penable & ~pwrite;

  // direct address: access bank split or bank select nibble
  always @* begin
    sel_bank = bank_select_reg[3:0]; // [RULE1]
    if (core_access) begin
      sel_bank = (core_addr < `DMAF_ACC_SPLIT) ? 4'h0 : 4'hF; // [RULE6]
    end
  end
  // move file to file takes the whole address [RULE5]
  assign full_addr = core_mff ? core_mff_addr : {sel_bank, core_addr}; // [RULE4]

  // indirect location decode: which pointer and which mode
  // every pointer owns five consecutive addresses, the low three bits less three give the mode
  function [5:0] dmaf_ind_decode;
    input [11:0] a;
    reg [1:0] p;
    reg [2:0] m;
    reg hit;
    begin
      p = 2'd0;
      m = 3'd0;
      hit = 1'b0;
      if (a >= `DMAF_ADR_IDX2 && a <= `DMAF_ADR_PLAIN2) begin
        hit = 1'b1;
        p = 2'd2;
        m = a[2:0] - 3'd3;
      end else if (a >= `DMAF_ADR_IDX1 && a <= `DMAF_ADR_PLAIN1) begin
        hit = 1'b1;
        p = 2'd1;
        m = a[2:0] - 3'd3;
      end else if (a >= `DMAF_ADR_IDX0 && a <= `DMAF_ADR_PLAIN0) begin
        hit = 1'b1;
        p = 2'd0;
        m = a[2:0] - 3'd3;
      end
      dmaf_ind_decode = {hit, p, m};
    end
  endfunction

  // effective address; modes 0 indexed, 1 preinc, 2 postdec, 3 postinc, 4 plain [RULE10]
  always @* begin
    {is_ind, ind_sel, ind_mode} = dmaf_ind_decode(full_addr); // [RULE8]
    eff_addr = full_addr;
    if (is_ind) begin
      eff_addr = indirect_pointer[ind_sel];
      if (ind_mode == 3'd0) begin
        // sign-extended offset, sum wraps in 12 bits [RULE11] [RULE24]
        eff_addr = indirect_pointer[ind_sel] + {{4{working_register[7]}}, working_register};
      end else if (ind_mode == 3'd1) begin
        eff_addr = indirect_pointer[ind_sel] + 12'h001;
      end
    end
    // a pointer aiming at an indirect location would loop, so the access is refused
    self_dec = dmaf_ind_decode(eff_addr);
    self_ptr = is_ind & self_dec[5]; // [RULE9]
  end

  // a bank left out of the implemented mask neither stores nor answers, except the registers held here [RULE3]
  assign bank_ok = bank_impl[eff_addr[11:8]];

  // registers held here answer core reads themselves, not the ram copy [RULE7]
  always @* begin
    loc_hit = 1'b1;
    case (eff_addr)
      `DMAF_ADR_FLAGS: loc_data = alu_flags;
      `DMAF_ADR_BANK: loc_data = bank_select_reg;
      `DMAF_ADR_PTR0_LO: loc_data = indirect_pointer[0][7:0];
      `DMAF_ADR_PTR0_HI: loc_data = {4'h0, indirect_pointer[0][11:8]};
      `DMAF_ADR_PTR1_LO: loc_data = indirect_pointer[1][7:0];
      `DMAF_ADR_PTR1_HI: loc_data = {4'h0, indirect_pointer[1][11:8]};
      `DMAF_ADR_PTR2_LO: loc_data = indirect_pointer[2][7:0];
      `DMAF_ADR_PTR2_HI: loc_data = {4'h0, indirect_pointer[2][11:8]};
      default: begin
        loc_data = 8'h00;
        loc_hit = 1'b0;
      end
    endcase
  end

  // alu flag computation, write suppression of the five flags
  always @* begin
    next_flags = alu_flags;
    // subtract adds the inverted operand plus carry in, so carries read as inverted borrows
    b_eff = (alu_op == `DMAF_OP_SUB) ? ~alu_b : alu_b; // [RULE23]
    sum9 = {1'b0, alu_a} + {1'b0, b_eff} + {8'h00, alu_cin};
    sum5 = {1'b0, alu_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, alu_cin};
    case (alu_op)
      `DMAF_OP_ADD, `DMAF_OP_SUB: begin
        next_flags[`DMAF_F_C] = sum9[8]; // [RULE21]
        next_flags[`DMAF_F_DIGIT] = sum5[4]; // [RULE20]
        next_flags[`DMAF_F_WRAP] = (alu_a[7] == b_eff[7]) && (sum9[7] != alu_a[7]); // [RULE18]
        next_flags[`DMAF_F_Z] = (alu_result == 8'h00); // [RULE19]
        next_flags[`DMAF_F_N] = alu_result[7]; // [RULE17]
      end
      `DMAF_OP_LOGIC: begin
        next_flags[`DMAF_F_Z] = (alu_result == 8'h00);
        next_flags[`DMAF_F_N] = alu_result[7];
      end
      `DMAF_OP_RLEFT: begin
        next_flags[`DMAF_F_C] = alu_a[7]; // [RULE22]
        next_flags[`DMAF_F_DIGIT] = alu_a[3];
        next_flags[`DMAF_F_Z] = (alu_result == 8'h00);
        next_flags[`DMAF_F_N] = alu_result[7];
      end
      `DMAF_OP_RRIGHT: begin
        next_flags[`DMAF_F_C] = alu_a[0];
        next_flags[`DMAF_F_DIGIT] = alu_a[4];
        next_flags[`DMAF_F_Z] = (alu_result == 8'h00);
        next_flags[`DMAF_F_N] = alu_result[7];
      end
      default: begin
        next_flags = alu_flags;
      end
    endcase
    // a data write reaches the flag register only when no alu result claims it
    if (core_req & core_we & (eff_addr == `DMAF_ADR_FLAGS) & (alu_op == `DMAF_OP_NONE)) begin
      next_flags = {3'b000, core_wdata[4:0]};
    end
    if (core_req & ~core_we & self_ptr) begin
      next_flags[`DMAF_F_Z] = 1'b1; // [RULE9]
    end
    next_flags[7:5] = 3'b000; // [RULE16]
  end

  // pointer, bank and flag registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      indirect_pointer[0] <= `DMAF_RST_PTR;
      indirect_pointer[1] <= `DMAF_RST_PTR;
      indirect_pointer[2] <= `DMAF_RST_PTR;
      bank_select_reg <= `DMAF_RST_BANK;
      alu_flags <= {3'b000, `DMAF_RST_FLAGS};
      bank_impl <= `DMAF_RST_IMPL;
    end else begin
      // auto step on 12 bits, flags untouched [RULE12] [RULE13]
      // a refused self-pointing access leaves the pointer where it is
      if (core_req & is_ind & ~self_ptr) begin
        if (ind_mode == 3'd1 || ind_mode == 3'd3) begin
          indirect_pointer[ind_sel] <= indirect_pointer[ind_sel] + 12'h001;
        end else if (ind_mode == 3'd2) begin
          indirect_pointer[ind_sel] <= indirect_pointer[ind_sel] - 12'h001;
        end
      end
      // core writes to pointer bytes come later and win [RULE7] [RULE14]
      if (core_req & core_we & ~self_ptr) begin
        case (eff_addr)
          `DMAF_ADR_PTR0_LO: indirect_pointer[0][7:0] <= core_wdata;
          `DMAF_ADR_PTR0_HI: indirect_pointer[0][11:8] <= core_wdata[3:0];
          `DMAF_ADR_PTR1_LO: indirect_pointer[1][7:0] <= core_wdata;
          `DMAF_ADR_PTR1_HI: indirect_pointer[1][11:8] <= core_wdata[3:0];
          `DMAF_ADR_PTR2_LO: indirect_pointer[2][7:0] <= core_wdata;
          `DMAF_ADR_PTR2_HI: indirect_pointer[2][11:8] <= core_wdata[3:0];
          `DMAF_ADR_BANK: bank_select_reg <= {4'h0, core_wdata[3:0]}; // [RULE2]
          default: begin
          end
        endcase
      end
      if (core_bank_load) begin
        bank_select_reg <= {4'h0, core_bank_lit[3:0]};
      end
      // computed flags win over a data write to the flag register [RULE15]
      if (core_req | (alu_op != `DMAF_OP_NONE)) begin
        alu_flags <= next_flags;
      end
      // apb writes
      if (apb_wr) begin
        case (paddr)
          `DMAF_OFF_BANK: bank_select_reg <= {4'h0, pwdata[3:0]};
          // an alu result in the same cycle outranks the bus write
          `DMAF_OFF_FLAGS: begin
            if (alu_op == `DMAF_OP_NONE) begin
              alu_flags <= {3'b000, pwdata[4:0]};
            end
          end
          `DMAF_OFF_PTR0: indirect_pointer[0] <= pwdata[11:0];
          `DMAF_OFF_PTR1: indirect_pointer[1] <= pwdata[11:0];
          `DMAF_OFF_PTR2: indirect_pointer[2] <= pwdata[11:0];
          `DMAF_OFF_CTRL: bank_impl <= pwdata[15:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ram strobes and read return
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_en <= 1'b0;
      ram_we <= 1'b0;
      ram_addr <= 12'h000;
      ram_wdata <= 8'h00;
      rd_state <= ST_IDLE;
      rd_zero <= 1'b0;
      rd_use_local <= 1'b0;
      rd_local <= 8'h00;
      core_rdata <= 8'h00;
      core_rvalid <= 1'b0;
    end else begin
      ram_en <= 1'b0;
      ram_we <= 1'b0;
      core_rvalid <= 1'b0;
      case (rd_state)
        ST_IDLE: begin
          if (core_req) begin
            ram_addr <= eff_addr;
            ram_wdata <= core_wdata;
            // missing bank: ram write dropped, read zero unless a register held here [RULE3]
            ram_en <= ~self_ptr & bank_ok;
            ram_we <= core_we & ~self_ptr & bank_ok;
            if (!core_we) begin
              rd_zero <= self_ptr | (~bank_ok & ~loc_hit);
              rd_use_local <= loc_hit;
              rd_local <= loc_data;
              rd_state <= ST_WAIT;
            end
          end
        end
        // requests arriving here get no ram access or read answer, but still step pointers and write registers; the core spaces its reads
        ST_WAIT: begin
          core_rvalid <= 1'b1;
          core_rdata <= rd_zero ? 8'h00 : (rd_use_local ? rd_local : ram_rdata);
          rd_state <= ST_IDLE;
        end
        default: begin
          rd_state <= ST_IDLE;
        end
      endcase
    end
  end

  // apb read mux
  always @* begin
    addr_ok = 1'b1;
    case (paddr)
      `DMAF_OFF_BANK: rd_mux = {24'h0, bank_select_reg};
      `DMAF_OFF_FLAGS: rd_mux = {24'h0, alu_flags};
      `DMAF_OFF_PTR0: rd_mux = {20'h0, indirect_pointer[0]};
      `DMAF_OFF_PTR1: rd_mux = {20'h0, indirect_pointer[1]};
      `DMAF_OFF_PTR2: rd_mux = {20'h0, indirect_pointer[2]};
      `DMAF_OFF_CTRL: rd_mux = {16'h0, bank_impl};
      `DMAF_OFF_STAT: rd_mux = {30'h0, rd_state};
      default: begin
        rd_mux = 32'h0;
        addr_ok = 1'b0;
      end
    endcase
  end

  // apb answer: zero wait, error on unmapped address
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // pready follows every setup cycle, so a transfer never waits
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      if (apb_rd) begin
        prdata <= rd_mux;
      end
    end
  end

endmodule // dmaf_top
`default_nettype wire

// ===== pkg/dmaf_map.vh
// Purpose: constants for the data memory addressing and flag block
// Assumes: 32-bit APB data, byte addresses
// Notes: register offsets are byte addresses on the APB side
`ifndef DMAF_MAP_VH
`define DMAF_MAP_VH
// apb register offsets
`define DMAF_OFF_BANK 12'h000
`define DMAF_OFF_FLAGS 12'h004
`define DMAF_OFF_PTR0 12'h008
`define DMAF_OFF_PTR1 12'h00C
`define DMAF_OFF_PTR2 12'h010
`define DMAF_OFF_CTRL 12'h014
`define DMAF_OFF_STAT 12'h018
// reset values
`define DMAF_RST_BANK 8'h00
`define DMAF_RST_FLAGS 5'h00
`define DMAF_RST_PTR 12'h000
`define DMAF_RST_IMPL 16'hFFFF
// flag bit positions
`define DMAF_F_C 0
`define DMAF_F_DIGIT 1
`define DMAF_F_Z 2
`define DMAF_F_WRAP 3
`define DMAF_F_N 4
// core-side data addresses of the pointer, indirect, flag and bank locations, and the access bank split
`define DMAF_ADR_IDX2 12'hFDB
`define DMAF_ADR_PRE2 12'hFDC
`define DMAF_ADR_PDEC2 12'hFDD
`define DMAF_ADR_PINC2 12'hFDE
`define DMAF_ADR_PLAIN2 12'hFDF
`define DMAF_ADR_IDX1 12'hFE3
`define DMAF_ADR_PLAIN1 12'hFE7
`define DMAF_ADR_IDX0 12'hFEB
`define DMAF_ADR_PLAIN0 12'hFEF
`define DMAF_ADR_PTR2_LO 12'hFD9
`define DMAF_ADR_PTR2_HI 12'hFDA
`define DMAF_ADR_PTR1_LO 12'hFE1
`define DMAF_ADR_PTR1_HI 12'hFE2
`define DMAF_ADR_PTR0_LO 12'hFE9
`define DMAF_ADR_PTR0_HI 12'hFEA
`define DMAF_ADR_FLAGS 12'hFD8
`define DMAF_ADR_BANK 12'hFE0
`define DMAF_ACC_SPLIT 8'h60
// alu operations
`define DMAF_OP_NONE 3'h0
`define DMAF_OP_ADD 3'h1
`define DMAF_OP_SUB 3'h2
`define DMAF_OP_LOGIC 3'h3
`define DMAF_OP_RLEFT 3'h4
`define DMAF_OP_RRIGHT 3'h5
`endif

// ===== tb/dmaf_chk.sv
// Purpose: port checker for dmaf_top
// Assumes: bench keeps core reads two cycles apart
// Notes: bound at the foot of this file
`timescale 1ns/10ps
`default_nettype none
`include "dmaf_map.vh"
module dmaf_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // core request
  input wire logic core_req,
  input wire logic core_we,
  input wire logic [7:0] core_addr,
  input wire logic core_access,
  input wire logic core_mff,
  input wire logic [11:0] core_mff_addr,
  input wire logic core_bank_load,
  input wire logic [7:0] core_bank_lit,
  // alu
  input wire logic [2:0] alu_op,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  input wire logic alu_cin,
  input wire logic [7:0] alu_result,
  // answers
  input wire logic core_rvalid,
  input wire logic [7:0] alu_flags,
  input wire logic [7:0] bank_select_reg,
  input wire logic ram_en,
  input wire logic [11:0] ram_addr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // reference carries for add and subtract
  wire [8:0] add_s = {1'b0, alu_a} + {1'b0, alu_b} + {8'h00, alu_cin};
  wire [8:0] sub_s = alu_a + {1'b0, ~alu_b} + alu_cin;
  bank_hi_a: assert property (bank_select_reg[7:4] == 4'h0)
    else $error("bank high nibble set");
  flag_hi_a: assert property (alu_flags[7:5] == 3'h0)
    else $error("flag top bits set");
  bank_load_a: assert property (core_bank_load |=> bank_select_reg == {4'h0, $past(core_bank_lit[3:0])})
    else $error("bank literal not loaded");
  direct_adr_a: assert property (core_req && !core_mff && !core_access && bank_select_reg[3:0] != 4'hF
    |=> ram_en |-> ram_addr == {$past(bank_select_reg[3:0]), $past(core_addr)}) else $error("direct address");
  mff_adr_a: assert property (core_req && core_mff && core_mff_addr < 12'hF00
    |=> ram_en && ram_addr == $past(core_mff_addr)) else $error("full address");
  acc_low_a: assert property (core_req && !core_mff && core_access && core_addr < 8'h60
    |=> ram_en && ram_addr == {4'h0, $past(core_addr)}) else $error("access bank address");
  read_lat_a: assert property (core_req && !core_we |-> ##2 core_rvalid)
    else $error("read answer late");
  neg_flag_a: assert property (alu_op inside {`DMAF_OP_ADD, `DMAF_OP_SUB, `DMAF_OP_LOGIC}
    |=> alu_flags[4] == $past(alu_result[7])) else $error("negative flag");
  zero_flag_a: assert property (alu_op == `DMAF_OP_LOGIC |=> alu_flags[2] == ($past(alu_result) == 8'h00))
    else $error("zero flag");
  add_carry_a: assert property (alu_op == `DMAF_OP_ADD |=> alu_flags[0] == $past(add_s[8]))
    else $error("add carry");
  sub_carry_a: assert property (alu_op == `DMAF_OP_SUB |=> alu_flags[0] == $past(sub_s[8]))
    else $error("subtract borrow");
  cover property (core_req && core_mff);
  cover property (alu_op == `DMAF_OP_SUB);
  cover property (core_bank_load);
endmodule // dmaf_chk
bind dmaf_top dmaf_chk u_dmaf_chk (.pclk(pclk), .presetn(presetn), .core_req(core_req), .core_we(core_we),
  .core_addr(core_addr), .core_access(core_access), .core_mff(core_mff), .core_mff_addr(core_mff_addr),
  .core_bank_load(core_bank_load), .core_bank_lit(core_bank_lit), .alu_op(alu_op), .alu_a(alu_a),
  .alu_b(alu_b), .alu_cin(alu_cin), .alu_result(alu_result), .core_rvalid(core_rvalid),
  .alu_flags(alu_flags), .bank_select_reg(bank_select_reg), .ram_en(ram_en), .ram_addr(ram_addr));
`default_nettype wire

// ===== tb/dmaf_ram.sv
// Purpose: banked static ram behind the block
// Assumes: read data valid in the cycle ram_en is high
// Notes: read data scrambles outside its valid cycle
`timescale 1ns/10ps
`default_nettype none
module dmaf_ram (
  // clock
  input wire logic pclk,
  // ram port
  input wire logic ram_en,
  input wire logic ram_we,
  input wire logic [11:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  output var logic [7:0] ram_rdata
);
  logic [7:0] mem [0:4095]; // sixteen banks of 256 bytes
  // write one byte on the clock
  always @(posedge pclk) begin
    if (ram_en && ram_we) mem[ram_addr] <= ram_wdata;
  end
  // read follows the address on an enabled read; a write cycle or a deselected port shows the inverse
  always_comb begin
    ram_rdata = (ram_en && !ram_we) ? mem[ram_addr] : ~mem[ram_addr];
  end
endmodule // dmaf_ram
`default_nettype wire

// ===== tb/test_dmaf_top.sv
// Purpose: bench for dmaf_top
// Assumes: core strobes are one-cycle pulses
// Notes: ram model on the far side
`timescale 1ns/10ps
`default_nettype none
`include "dmaf_map.vh"
module test_dmaf_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic [11:0] paddr = 0, mff = 0, ra;
  logic [31:0] pwdata = 0, prdata, q;
  logic req = 0, we = 0, acc = 0, mf = 0, bl = 0, cin = 0, rv, re, rw;
  logic [7:0] ad = 0, wd = 0, w = 0, lit = 0, a = 0, b = 0, res = 0, rd, fl, bs, rwd, rrd;
  logic [2:0] op = 0;
  logic [11:0] ta [5] = '{12'hFEE, 12'hFED, 12'hFEC, 12'hFEB, 12'hFEF};
  logic [7:0] td [5] = '{8'h11, 8'h22, 8'h22, 8'h11, 8'h22};
  logic [11:0] tp [5] = '{12'h100, 12'h0FF, 12'h100, 12'h100, 12'h100};
  int error_cnt = 0, n_checks = 0, k;
  initial forever #10 pclk = ~pclk;
  dmaf_top u_dmaf_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_req(req),
    .core_we(we), .core_addr(ad), .core_access(acc), .core_mff(mf), .core_mff_addr(mff), .core_wdata(wd),
    .working_register(w), .core_bank_load(bl), .core_bank_lit(lit), .alu_op(op), .alu_a(a), .alu_b(b),
    .alu_cin(cin), .alu_result(res), .core_rdata(rd), .core_rvalid(rv), .alu_flags(fl), .bank_select_reg(bs),
    .ram_en(re), .ram_we(rw), .ram_addr(ra), .ram_wdata(rwd), .ram_rdata(rrd));
  dmaf_ram u_dmaf_ram (.pclk(pclk), .ram_en(re), .ram_we(rw), .ram_addr(ra), .ram_wdata(rwd), .ram_rdata(rrd));
  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one apb transfer, waits for pready
  task apb(input logic wr, input logic [11:0] x, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= x;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 9; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 9) begin
      error_cnt++;
      summarize;
    end
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rdc(input logic [11:0] x, input logic [31:0] exp);
    apb(0, x, 0);
    chk(q, exp);
  endtask
  // one core access; reads wait for core_rvalid
  task cor(input logic w_i, m_i, c_i, input logic [11:0] x, input logic [7:0] d, exp);
    int i;
    @(posedge pclk);
    req <= 1;
    we <= w_i;
    mf <= m_i;
    acc <= c_i;
    mff <= x;
    ad <= x[7:0];
    wd <= d;
    @(posedge pclk);
    req <= 0;
    for (i = 0; i < 4 && !w_i; i++) begin
      @(posedge pclk);
      if (rv === 1'b1) break;
    end
    if (i == 4) begin
      error_cnt++;
      summarize;
    end
    if (!w_i) chk(rd, exp);
  endtask
  // one alu flag update
  task alu(input logic [2:0] o, input logic [7:0] x, y, r, input logic c);
    @(posedge pclk);
    op <= o;
    a <= x;
    b <= y;
    res <= r;
    cin <= c;
    @(posedge pclk);
    op <= 0;
    @(posedge pclk);
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    rdc(`DMAF_OFF_BANK, 0);
    rdc(`DMAF_OFF_CTRL, 32'hFFFF);
    rdc(12'h01C, 0);
    chk(e, 1);
    apb(1, `DMAF_OFF_BANK, 32'hFF);
    rdc(`DMAF_OFF_BANK, 32'h0F);
    @(posedge pclk);
    bl <= 1;
    lit <= 8'hA3;
    @(posedge pclk);
    bl <= 0;
    rdc(`DMAF_OFF_BANK, 32'h03);
    cor(1, 0, 0, 12'h045, 8'h5A, 0);
    cor(0, 1, 0, 12'h345, 0, 8'h5A);
    cor(1, 0, 1, 12'h045, 8'h6B, 0);
    cor(0, 1, 0, 12'h045, 0, 8'h6B);
    apb(1, `DMAF_OFF_CTRL, 32'hFFF7);
    cor(0, 0, 0, 12'h045, 0, 0);
    apb(1, `DMAF_OFF_CTRL, 32'hFFFF);
    cor(1, 1, 0, `DMAF_ADR_FLAGS, 0, 0);
    w <= 8'hFF;
    apb(1, `DMAF_OFF_PTR0, 32'h0FF);
    for (k = 0; k < 5; k++) begin
      cor(k < 2, 1, 0, ta[k], td[k], td[k]);
      rdc(`DMAF_OFF_PTR0, tp[k]);
    end
    chk(fl, 0);
    apb(1, `DMAF_OFF_PTR0, 32'hFEF);
    cor(0, 1, 0, 12'hFEF, 0, 0);
    chk(fl, 8'h04);
    cor(1, 1, 0, 12'hFEE, 8'h55, 0);
    rdc(`DMAF_OFF_PTR0, 32'hFEF);
    chk(fl, 8'h04);
    apb(1, `DMAF_OFF_PTR0, 32'hFE9);
    cor(1, 1, 0, 12'hFEE, 8'h40, 0);
    rdc(`DMAF_OFF_PTR0, 32'hF40);
    alu(`DMAF_OP_ADD, 8'h7F, 8'h01, 8'h80, 0);
    chk(fl, 8'h1A);
    alu(`DMAF_OP_SUB, 8'h05, 8'h05, 8'h00, 1);
    chk(fl, 8'h07);
    alu(`DMAF_OP_RLEFT, 8'h88, 8'h00, 8'h10, 0);
    chk(fl & 8'h03, 8'h03);
    alu(`DMAF_OP_RRIGHT, 8'h01, 8'h00, 8'h00, 0);
    chk(fl & 8'h03, 8'h01);
    @(posedge pclk);
    op <= `DMAF_OP_LOGIC;
    res <= 8'h80;
    req <= 1;
    we <= 1;
    mf <= 1;
    mff <= `DMAF_ADR_FLAGS;
    wd <= 8'h04;
    @(posedge pclk);
    op <= 0;
    req <= 0;
    repeat (2) @(posedge pclk);
    chk(fl & 8'hF4, 8'h10);
    cor(1, 1, 0, `DMAF_ADR_FLAGS, 8'hFF, 0);
    rdc(`DMAF_OFF_FLAGS, 32'h1F);
    summarize;
  end
endmodule // test_dmaf_top
`default_nettype wire
